// ### verilog/ivs_pkg.sv
// Constants and carrier types for the interrupt vector, status and command registers.
// Assumes a 4 KB register window addressed by byte, one 32-bit word per register.
package ivs_pkg;

   // Geometry of the register window and the source set.
   localparam int NUM_SRC   = 32;
   localparam int ADDR_W    = 12;
   localparam int DATA_W    = 32;
   localparam int SRC_W     = 5;

   // Byte offsets of the registers.
   localparam logic [11:0] OFF_VEC_BASE = 12'h080;
   localparam logic [11:0] OFF_NVEC     = 12'h100;
   localparam logic [11:0] OFF_FVEC     = 12'h104;
   localparam logic [11:0] OFF_CUR      = 12'h108;
   localparam logic [11:0] OFF_PEND     = 12'h10C;
   localparam logic [11:0] OFF_MASK     = 12'h110;
   localparam logic [11:0] OFF_CORE     = 12'h114;
   localparam logic [11:0] OFF_EN_CMD   = 12'h120;
   localparam logic [11:0] OFF_DIS_CMD  = 12'h124;
   localparam logic [11:0] OFF_CLR_CMD  = 12'h128;
   localparam logic [11:0] OFF_SET_CMD  = 12'h12C;
   localparam logic [11:0] OFF_SPU      = 12'h134;
   localparam logic [11:0] OFF_EVT_STAT = 12'h150;
   localparam logic [11:0] OFF_EVT_MASK = 12'h154;

   // Vector slots occupy one aligned block; these pick it out of an address.
   localparam int          VEC_HI       = 11;
   localparam int          VEC_LO       = 7;
   localparam logic [4:0]  VEC_BLOCK    = 5'h01;
   localparam int          VEC_IDX_LO   = 2;

   // Field positions.
   localparam int FAST_SOURCE_BIT   = 0;
   localparam int SYSTEM_SOURCE_BIT = 1;
   localparam int FAST_LINE_STATE   = 0;
   localparam int NORMAL_LINE_STATE = 1;
   localparam int EVT_NEW_PEND      = 0;
   localparam int EVT_LINE_RISE     = 1;
   localparam int EVT_W             = 2;

   // Reset values.
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0]  RST_EVT  = 2'h0;

   // One register access from software.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } ivs_bus_t;

   // The whole state of the block apart from the vector slots.
   typedef struct packed {
      logic [NUM_SRC-1:0] mask;
      logic [NUM_SRC-1:0] pending;
      logic [DATA_W-1:0]  spu;
      logic [DATA_W-1:0]  rdata;
      logic               fast_act;
      logic               norm_act;
      logic [EVT_W-1:0]   evt_stat;
      logic [EVT_W-1:0]   evt_mask;
      logic               irq;
   } ivs_state_t;

endpackage

// ### verilog/ivs_regs.sv
// Vector readout, status readout and per-source command registers of a vectored
// interrupt controller. Assumes the priority resolver outside supplies the current
// source number and a valid flag, and that source requests arrive as set pulses.
`timescale 1ns/1ps

// Summary of operation
// - A normal vector read returns the stored handler address of the current source.
// - The read itself indexes the vector slots with the current source number.
// - With no current interrupt the normal vector read returns the spurious vector.
// - A fast vector read returns the handler address stored in slot 0.
// - With no fast interrupt the fast vector read returns the spurious vector.
// - The status register shows the current source number in its low field.
// - The pending register has one bit per source, bit 0 fast and bit 1 system.
// - The mask register reads 1 for each enabled source and 0 for each disabled one.
// - Core status bit 0 shows whether the fast request line is active.
// - Core status bit 1 shows whether the normal request line is active.
// - Writing the enable command enables each source written as 1, others unchanged.
// - Writing the disable command disables each source written as 1, others unchanged.
// - Writing the clear command clears pending on each source written as 1 and not set by a source request in that cycle.
// - Writing the set command makes each source written as 1 pending.
module ivs_regs
   import ivs_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               reset,
   input  wire ivs_bus_t           bus,
   output logic [DATA_W-1:0]       rdata,
   input  wire logic [NUM_SRC-1:0] src_set,
   input  wire logic               cur_valid,
   input  wire logic [SRC_W-1:0]   cur_src,
   output logic                    fast_request_line_n,
   output logic                    normal_request_line_n,
   output logic                    irq
);

   // True when the address falls in the vector slot block.
   function automatic logic is_vec(input logic [ADDR_W-1:0] a);
      return a[VEC_HI:VEC_LO] == VEC_BLOCK;
   endfunction

   // Slot index carried by a vector block address.
   function automatic logic [SRC_W-1:0] vec_idx(input logic [ADDR_W-1:0] a);
      return a[VEC_IDX_LO+SRC_W-1:VEC_IDX_LO];
   endfunction

   ivs_state_t          st;
   ivs_state_t          next_st;
   logic [DATA_W-1:0]   vec [NUM_SRC];
   logic [DATA_W-1:0]   vec_cur;
   logic [DATA_W-1:0]   vec_fast;
   logic [NUM_SRC-1:0]  en_bits;
   logic [NUM_SRC-1:0]  dis_bits;
   logic [NUM_SRC-1:0]  clr_bits;
   logic [NUM_SRC-1:0]  sw_set_bits;
   logic [NUM_SRC-1:0]  set_all;
   logic [EVT_W-1:0]    evt_hit;
   logic                next_fast;
   logic                next_norm;

   // The slot lookups are combinational so a read sees the number of that very cycle.
   assign vec_cur  = vec[cur_src];
   assign vec_fast = vec[FAST_SOURCE_BIT];

   // Vector slots; software writes them, the readout only looks at them.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            vec[i] <= RST_WORD;
         end
      end else if (bus.wr && is_vec(bus.addr)) begin
         vec[vec_idx(bus.addr)] <= bus.wdata;
      end
   end

   // Next-state logic for every register of the block apart from the vector slots.
   always_comb begin
      next_st     = st;
      en_bits     = '0;
      dis_bits    = '0;
      clr_bits    = '0;
      sw_set_bits = '0;
      evt_hit     = '0;
      if (bus.wr) begin
         case (bus.addr)
            OFF_EN_CMD:   en_bits     = bus.wdata;
            OFF_DIS_CMD:  dis_bits    = bus.wdata;
            OFF_CLR_CMD:  clr_bits    = bus.wdata;
            OFF_SET_CMD:  sw_set_bits = bus.wdata;
            OFF_SPU:      next_st.spu = bus.wdata;
            OFF_EVT_MASK: next_st.evt_mask = bus.wdata[EVT_W-1:0];
            default:      ;
         endcase
      end

      // Enable and disable never share a cycle, so the order below is only a tie rule.
      next_st.mask = (st.mask | en_bits) & ~dis_bits;

      // A source request landing with a clear keeps the source pending.
      set_all         = src_set | sw_set_bits;
      next_st.pending = (st.pending & ~clr_bits) | set_all;

      // Request lines are computed from the next state, so they change in the same cycle as the enabled pending sources.
      next_fast = next_st.pending[FAST_SOURCE_BIT] & next_st.mask[FAST_SOURCE_BIT];
      next_norm = |(next_st.pending[NUM_SRC-1:SYSTEM_SOURCE_BIT]
                    & next_st.mask[NUM_SRC-1:SYSTEM_SOURCE_BIT]);
      next_st.fast_act = next_fast;
      next_st.norm_act = next_norm;

      // Events: a source newly pending, or the normal line going active.
      evt_hit[EVT_NEW_PEND]  = |(set_all & ~st.pending);
      evt_hit[EVT_LINE_RISE] = next_norm & ~st.norm_act;
      if (bus.wr && bus.addr == OFF_EVT_STAT) begin
         next_st.evt_stat = st.evt_stat & ~bus.wdata[EVT_W-1:0];
      end
      // Setting after clearing lets a same-cycle event survive its clear.
      next_st.evt_stat = next_st.evt_stat | evt_hit;
      next_st.irq      = |(next_st.evt_stat & next_st.evt_mask);

      // Read data stand only in the cycle after the strobe.
      next_st.rdata = '0;
      if (bus.rd) begin
         if (is_vec(bus.addr)) begin
            next_st.rdata = vec[vec_idx(bus.addr)];
         end else begin
            case (bus.addr)
               OFF_NVEC: next_st.rdata = cur_valid ? vec_cur : st.spu;
               OFF_FVEC: next_st.rdata = st.fast_act ? vec_fast : st.spu;
               OFF_CUR:  next_st.rdata = {{(DATA_W-SRC_W){1'b0}}, cur_src};
               OFF_PEND: next_st.rdata = st.pending;
               OFF_MASK: next_st.rdata = st.mask;
               OFF_CORE: begin
                  next_st.rdata[FAST_LINE_STATE]   = st.fast_act;
                  next_st.rdata[NORMAL_LINE_STATE] = st.norm_act;
               end
               OFF_SPU:      next_st.rdata = st.spu;
               OFF_EVT_STAT: next_st.rdata = {{(DATA_W-EVT_W){1'b0}}, st.evt_stat};
               OFF_EVT_MASK: next_st.rdata = {{(DATA_W-EVT_W){1'b0}}, st.evt_mask};
               default:      next_st.rdata = '0;
            endcase
         end
      end
   end

   // State register; everything resets to zero, lines inactive.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= '{mask: RST_WORD, pending: RST_WORD, spu: RST_WORD, rdata: RST_WORD,
                 fast_act: 1'b0, norm_act: 1'b0, evt_stat: RST_EVT,
                 evt_mask: RST_EVT, irq: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flops; the request lines are active low.
   assign rdata                 = st.rdata;
   assign fast_request_line_n   = ~st.fast_act;
   assign normal_request_line_n = ~st.norm_act;
   assign irq                   = st.irq;

   // Checks on the register behaviour.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_fast_ready;
      st.pending[FAST_SOURCE_BIT] && st.mask[FAST_SOURCE_BIT];
   endsequence

   // The line is registered beside the state, so it shows the ready state of its own cycle.
   sequence s_line_low;
      !fast_request_line_n;
   endsequence

   AST_NVEC_LOOKUP: assert property (bus.rd && bus.addr == OFF_NVEC && cur_valid
      |=> rdata == $past(vec_cur))
      else $error("normal vector read did not return the current slot");

   AST_NVEC_SPU: assert property (bus.rd && bus.addr == OFF_NVEC && !cur_valid
      |=> rdata == $past(st.spu))
      else $error("normal vector read with no current source missed spurious");

   AST_FVEC: assert property (bus.rd && bus.addr == OFF_FVEC
      |=> rdata == ($past(st.fast_act) ? $past(vec_fast) : $past(st.spu)))
      else $error("fast vector read returned the wrong word");

   AST_CUR: assert property (bus.rd && bus.addr == OFF_CUR
      |=> rdata == {27'h0, $past(cur_src)})
      else $error("status read did not show the current source");

   AST_CORE: assert property (bus.rd && bus.addr == OFF_CORE
      |=> rdata == {30'h0, ~$past(normal_request_line_n), ~$past(fast_request_line_n)})
      else $error("core status does not match the request lines");

   AST_EN: assert property (bus.wr && bus.addr == OFF_EN_CMD
      |=> (st.mask & $past(bus.wdata)) == $past(bus.wdata))
      else $error("enable command did not enable the written sources");

   AST_DIS: assert property (bus.wr && bus.addr == OFF_DIS_CMD
      |=> (st.mask & $past(bus.wdata)) == 32'h0)
      else $error("disable command did not disable the written sources");

   AST_HOLD: assert property (!(bus.wr && (bus.addr == OFF_EN_CMD
      || bus.addr == OFF_DIS_CMD)) |=> $stable(st.mask))
      else $error("mask changed without a command");

   AST_CLR: assert property (bus.wr && bus.addr == OFF_CLR_CMD
      |=> (st.pending & $past(bus.wdata) & ~$past(src_set)) == 32'h0)
      else $error("clear command left a source pending");

   AST_SET: assert property (bus.wr && bus.addr == OFF_SET_CMD
      |=> (st.pending & $past(bus.wdata)) == $past(bus.wdata))
      else $error("set command did not make the sources pending");

   AST_FAST_LINE: assert property (s_fast_ready ##1 s_fast_ready |-> s_line_low)
      else $error("fast request line not driven while fast source ready");

   // Checks on the readouts and command bits. They cost no gates, and each strobe check pins a
   // result to its strobe cycle so that a slip of one cycle shows up at once.
   sequence s_wr_at(logic [ADDR_W-1:0] a);
      bus.wr && bus.addr == a;
   endsequence

   sequence s_rd_at(logic [ADDR_W-1:0] a);
      bus.rd && bus.addr == a;
   endsequence

   // Some enabled source other than the fast one is pending.
   sequence s_norm_ready;
      |(st.pending[NUM_SRC-1:SYSTEM_SOURCE_BIT] & st.mask[NUM_SRC-1:SYSTEM_SOURCE_BIT]);
   endsequence

   // The fast source is not both pending and enabled.
   sequence s_fast_quiet;
      !(st.pending[FAST_SOURCE_BIT] && st.mask[FAST_SOURCE_BIT]);
   endsequence

   // No enabled source other than the fast one is pending.
   sequence s_norm_quiet;
      !(|(st.pending[NUM_SRC-1:SYSTEM_SOURCE_BIT] & st.mask[NUM_SRC-1:SYSTEM_SOURCE_BIT]));
   endsequence

   // Read data are zero in every cycle that does not follow a read strobe.
   AST_RDATA_IDLE: assert property (!bus.rd |=> rdata == 32'h0)
      else $error("read data did not return to zero");

   // The pending readout shows the state of the strobe cycle.
   AST_PEND_READ: assert property (s_rd_at(OFF_PEND) |=> rdata == $past(st.pending))
      else $error("pending read did not show the pending bits");

   // The mask readout shows the state of the strobe cycle.
   AST_MASK_READ: assert property (s_rd_at(OFF_MASK) |=> rdata == $past(st.mask))
      else $error("mask read did not show the enabled sources");

   // The spurious vector reads back as stored.
   AST_SPU_READ: assert property (s_rd_at(OFF_SPU) |=> rdata == $past(st.spu))
      else $error("spurious vector did not read back");

   // A write to the spurious vector lands whole.
   AST_SPU_WRITE: assert property (s_wr_at(OFF_SPU) |=> st.spu == $past(bus.wdata))
      else $error("spurious vector write did not land");

   // The spurious vector only changes on its own write.
   AST_SPU_HOLD: assert property (!(bus.wr && bus.addr == OFF_SPU)
      |=> $stable(st.spu))
      else $error("spurious vector changed without a write");

   // Source 0 current: the normal vector read must land on slot 0.
   AST_NVEC_SLOT0: assert property (s_rd_at(OFF_NVEC)
      ##0 (cur_valid && cur_src == 5'h00) |=> rdata == $past(vec_fast))
      else $error("normal vector read did not index slot 0");

   // With the fast line active the fast vector read returns slot 0.
   AST_FVEC_SLOT0: assert property (s_rd_at(OFF_FVEC)
      ##0 !fast_request_line_n |=> rdata == $past(vec_fast))
      else $error("fast vector read did not return slot 0");

   // With the fast line idle the fast vector read returns the spurious vector.
   AST_FVEC_SPU: assert property (s_rd_at(OFF_FVEC)
      ##0 fast_request_line_n |=> rdata == $past(st.spu))
      else $error("fast vector read with no fast interrupt missed spurious");

   // The fast line stays idle unless the fast source is pending and enabled.
   AST_FAST_IDLE: assert property (s_fast_quiet |-> fast_request_line_n)
      else $error("fast request line active with nothing ready");

   // Any enabled pending source other than the fast one drives the normal line.
   AST_NORM_LINE: assert property (s_norm_ready |-> !normal_request_line_n)
      else $error("normal request line idle while a source is ready");

   // The normal line stays idle when no such source is ready.
   AST_NORM_IDLE: assert property (s_norm_quiet |-> normal_request_line_n)
      else $error("normal request line active with nothing ready");

   // Setting an enabled fast source drives the fast line one cycle later.
   AST_SET_FAST: assert property (s_wr_at(OFF_SET_CMD)
      ##0 (bus.wdata[FAST_SOURCE_BIT] && st.mask[FAST_SOURCE_BIT])
      |=> !fast_request_line_n)
      else $error("set command on the fast source left its line idle");

   // Clearing the fast source releases the fast line unless hardware sets it again.
   AST_CLR_FAST: assert property (s_wr_at(OFF_CLR_CMD)
      ##0 (bus.wdata[FAST_SOURCE_BIT] && !src_set[FAST_SOURCE_BIT])
      |=> fast_request_line_n)
      else $error("clear command on the fast source left its line active");

   // Disabling the fast source releases the fast line.
   AST_DIS_FAST: assert property (s_wr_at(OFF_DIS_CMD)
      ##0 bus.wdata[FAST_SOURCE_BIT] |=> fast_request_line_n)
      else $error("disable command on the fast source left its line active");

   // Enabling a pending non-fast source drives the normal line one cycle later.
   AST_EN_NORM: assert property (s_wr_at(OFF_EN_CMD)
      ##0 (|(bus.wdata[NUM_SRC-1:SYSTEM_SOURCE_BIT] & st.pending[NUM_SRC-1:SYSTEM_SOURCE_BIT]))
      |=> !normal_request_line_n)
      else $error("enable of a pending source left the normal line idle");

   // Bits written as zero to the enable command leave their mask bits alone.
   AST_EN_KEEP: assert property (s_wr_at(OFF_EN_CMD)
      |=> ((st.mask ^ $past(st.mask)) & ~$past(bus.wdata)) == 32'h0)
      else $error("enable command changed an unwritten source");

   // Bits written as zero to the disable command leave their mask bits alone.
   AST_DIS_KEEP: assert property (s_wr_at(OFF_DIS_CMD)
      |=> ((st.mask ^ $past(st.mask)) & ~$past(bus.wdata)) == 32'h0)
      else $error("disable command changed an unwritten source");

   // Bits written as zero to the clear command keep their pending bits.
   AST_CLR_KEEP: assert property (s_wr_at(OFF_CLR_CMD)
      |=> ($past(st.pending) & ~$past(bus.wdata) & ~st.pending) == 32'h0)
      else $error("clear command cleared an unwritten source");

   // Bits written as zero to the set command raise nothing by themselves.
   AST_SET_KEEP: assert property (s_wr_at(OFF_SET_CMD)
      |=> ((st.pending ^ $past(st.pending)) & ~$past(bus.wdata) & ~$past(src_set)) == 32'h0)
      else $error("set command changed an unwritten source");

   // Pending bits never drop without a clear command.
   AST_PEND_HOLD: assert property (!(bus.wr && bus.addr == OFF_CLR_CMD)
      |=> ($past(st.pending) & ~st.pending) == 32'h0)
      else $error("pending bit dropped without a clear");

   // Pending bits only rise from a hardware request or a set command.
   AST_PEND_RISE: assert property (!(bus.wr && bus.addr == OFF_SET_CMD)
      |=> (st.pending & ~$past(st.pending) & ~$past(src_set)) == 32'h0)
      else $error("pending bit rose with no request");

   // An event in the very cycle of its write-one clear survives the clear.
   AST_EVT_SET_WINS: assert property (s_wr_at(OFF_EVT_STAT)
      |=> (st.evt_stat & $past(evt_hit)) == $past(evt_hit))
      else $error("event lost to a clear in the same cycle");

   // A write-one clear removes the written event bits when no new event lands.
   AST_EVT_CLEAR: assert property (s_wr_at(OFF_EVT_STAT)
      |=> (st.evt_stat & $past(bus.wdata[EVT_W-1:0]) & ~$past(evt_hit)) == 2'h0)
      else $error("event bit survived its clear");

   // The event mask takes the written bits.
   AST_EVT_MASK_WRITE: assert property (s_wr_at(OFF_EVT_MASK)
      |=> st.evt_mask == $past(bus.wdata[EVT_W-1:0]))
      else $error("event mask write did not land");

   // The event status reads back in its low bits with the rest zero.
   AST_EVT_STAT_READ: assert property (s_rd_at(OFF_EVT_STAT)
      |=> rdata == {30'h0, $past(st.evt_stat)})
      else $error("event status read returned the wrong word");

   // Writes to the read-only readouts change no stored word.
   AST_RO_WRITE: assert property (bus.wr
      && (bus.addr == OFF_NVEC || bus.addr == OFF_FVEC || bus.addr == OFF_CUR)
      |=> $stable(st.spu) && $stable(st.evt_mask) && $stable(st.evt_stat))
      else $error("write to a read-only readout changed state");

   // The interrupt output is high exactly while an unmasked event bit is set.
   AST_IRQ_LEVEL: assert property (irq == |(st.evt_stat & st.evt_mask))
      else $error("interrupt output disagrees with the event bits");

endmodule // ivs_regs

// ### tb/ivs_core_model.sv
// Model of the core's two interrupt request inputs.
// Assumes active-low request lines from the controller on the same clock.
`timescale 1ns/1ps
module ivs_core_model (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic fast_request_line_n,
   input  wire logic normal_request_line_n,
   output logic      fast_seen,
   output logic      normal_seen
);
   // The core samples its pins on the clock, so a glitch between edges is never seen.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         fast_seen   <= 1'b0;
         normal_seen <= 1'b0;
      end else begin
         fast_seen   <= ~fast_request_line_n;
         normal_seen <= ~normal_request_line_n;
      end
   end
endmodule // ivs_core_model

// ### tb/tb.sv
// Self-checking bench for the vector, status and command registers.
// Assumes the package offsets and a core model on the request lines.
`timescale 1ns/1ps
module tb
   import ivs_pkg::*;
;
   logic               ref_clk, reset, cur_valid, fast_n, norm_n, irq, f_seen, n_seen;
   ivs_bus_t           bus;
   logic [DATA_W-1:0]  rdata;
   logic [NUM_SRC-1:0] src_set;
   logic [SRC_W-1:0]   cur_src;
   int                 fails, n_checks;
   localparam logic [31:0] SPU = 32'h5EED_0BAD;
   localparam logic [31:0] V0  = 32'hF00D_0000;

   ivs_regs ivs_regs_i (.ref_clk(ref_clk), .reset(reset), .bus(bus), .rdata(rdata),
      .src_set(src_set), .cur_valid(cur_valid), .cur_src(cur_src),
      .fast_request_line_n(fast_n), .normal_request_line_n(norm_n), .irq(irq));
   ivs_core_model ivs_core_model_i (.ref_clk(ref_clk), .reset(reset),
      .fast_request_line_n(fast_n), .normal_request_line_n(norm_n),
      .fast_seen(f_seen), .normal_seen(n_seen));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // A write is one strobe cycle; the bench never overlaps the two strobes.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just after that edge.
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic t_reset();
      rdc(OFF_PEND, RST_WORD);
      rdc(OFF_MASK, RST_WORD);
      rdc(OFF_CORE, RST_WORD);
      rdc(12'h118, 32'h0);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, f_seen}, 32'h0);
      chk({31'h0, n_seen}, 32'h0);
   endtask
   task automatic t_vectors();
      wr(OFF_VEC_BASE, V0);
      wr(OFF_VEC_BASE + 12'h014, 32'h0000_5A05);
      wr(OFF_SPU, SPU);
      rdc(OFF_SPU, SPU);
      rdc(OFF_NVEC, SPU);
      rdc(OFF_FVEC, SPU);
      @(posedge ref_clk);
      cur_valid <= 1'b1;
      cur_src   <= 5'h05;
      rdc(OFF_NVEC, 32'h0000_5A05);
      rdc(OFF_CUR, 32'h0000_0005);
      @(posedge ref_clk);
      cur_src <= 5'h00;
      rdc(OFF_NVEC, V0);
      wr(OFF_FVEC, 32'h1234_5678);
      rdc(OFF_FVEC, SPU);
      @(posedge ref_clk);
      cur_valid <= 1'b0;
   endtask
   task automatic t_commands();
      wr(OFF_EN_CMD, 32'h8000_0003);
      rdc(OFF_MASK, 32'h8000_0003);
      wr(OFF_EN_CMD, 32'h0000_0010);
      rdc(OFF_MASK, 32'h8000_0013);
      wr(OFF_DIS_CMD, 32'h0000_0002);
      rdc(OFF_MASK, 32'h8000_0011);
      wr(OFF_SET_CMD, 32'h0000_0001);
      rdc(OFF_PEND, 32'h0000_0001);
      rdc(OFF_CORE, 32'h0000_0001);
      chk({31'h0, f_seen}, 32'h1);
      rdc(OFF_FVEC, V0);
      wr(OFF_SET_CMD, 32'h0000_0002);
      rdc(OFF_CORE, 32'h0000_0001);
      wr(OFF_EN_CMD, 32'h0000_0002);
      rdc(OFF_CORE, 32'h0000_0003);
      chk({31'h0, n_seen}, 32'h1);
      wr(OFF_CLR_CMD, 32'h0000_0001);
      rdc(OFF_PEND, 32'h0000_0002);
      rdc(OFF_FVEC, SPU);
      wr(OFF_CLR_CMD, 32'h0000_0000);
      rdc(OFF_PEND, 32'h0000_0002);
      wr(OFF_DIS_CMD, 32'hFFFF_FFFF);
      wr(OFF_CLR_CMD, 32'hFFFF_FFFF);
      rdc(OFF_MASK, 32'h0000_0000);
      rdc(OFF_CORE, 32'h0000_0000);
      chk({31'h0, f_seen}, 32'h0);
      chk({31'h0, n_seen}, 32'h0);
   endtask
   // A hardware request raises the event, then W1C and the mask each silence it.
   task automatic t_irq();
      // The set command and the normal line rising have both left their event bits.
      rdc(OFF_EVT_STAT, 32'h0000_0003);
      wr(OFF_EVT_STAT, 32'h0000_0003);
      wr(OFF_EVT_MASK, 32'h0000_0001);
      @(posedge ref_clk);
      src_set <= 32'h0000_0008;
      @(posedge ref_clk);
      src_set <= 32'h0;
      rdc(OFF_PEND, 32'h0000_0008);
      chk({31'h0, irq}, 32'h1);
      wr(OFF_EVT_STAT, 32'h0000_0001);
      repeat (2) @(posedge ref_clk);
      #1;
      chk({31'h0, irq}, 32'h0);
      wr(OFF_EVT_MASK, 32'h0000_0000);
      wr(OFF_SET_CMD, 32'h0000_0010);
      rdc(OFF_EVT_STAT, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0);
      // A write-one clear in the very cycle a new source turns pending loses to the event.
      @(posedge ref_clk);
      bus     <= '{addr: OFF_EVT_STAT, wdata: 32'h0000_0001, wr: 1'b1, rd: 1'b0};
      src_set <= 32'h0000_0020;
      @(posedge ref_clk);
      bus.wr  <= 1'b0;
      src_set <= 32'h0;
      rdc(OFF_EVT_STAT, 32'h0000_0001);
      rdc(OFF_PEND, 32'h0000_0038);
   endtask

   // Clock at 100 MHz.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Watchdog sized well above the 110 or so cycles the tests need.
   initial begin
      #20000;
      fails++;
      summarize();
   end
   // Main sequence.
   initial begin
      reset     = 1'b1;
      bus       = '0;
      src_set   = '0;
      cur_valid = 1'b0;
      cur_src   = '0;
      fails     = 0;
      n_checks  = 0;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_vectors();
      t_commands();
      t_irq();
      summarize();
   end
endmodule // tb
